// File: shared/csp_pkg.sv
`default_nettype none
package csp_pkg;
    // Register offsets on the plain register port
    localparam logic [3:0] OFS_BANK_PTR    = 4'h0;
    localparam logic [3:0] OFS_STATUS      = 4'h1;
    localparam logic [3:0] OFS_PC_LOW      = 4'h2;
    localparam logic [3:0] OFS_TBL_LOW     = 4'h3;
    localparam logic [3:0] OFS_TBL_HIGH    = 4'h4;
    localparam logic [3:0] OFS_TBL_LATCH   = 4'h5;
    localparam logic [3:0] OFS_ACC         = 4'h6;
    localparam logic [3:0] OFS_IRQ_STAT    = 4'h7;
    localparam logic [3:0] OFS_IRQ_MASK    = 4'h8;
    localparam logic [3:0] OFS_PC_HIGH     = 4'h9;
    // Status bit positions
    localparam int BIT_C   = 0;
    localparam int BIT_AC  = 1;
    localparam int BIT_Z   = 2;
    localparam int BIT_OV  = 3;
    localparam int BIT_PDF = 4;
    localparam int BIT_TO  = 5;
    localparam int BIT_CZ  = 6;
    localparam int BIT_SC  = 7;
    // Reset values and the software status write mask
    localparam logic [7:0] RST_BYTE   = 8'h00;
    localparam logic [7:0] RST_STATUS = 8'h00;
    localparam logic [7:0] SW_STATUS_MASK = 8'hCF;
    // Interrupt event bit positions
    localparam int EV_WDT_TIMEOUT = 0;
    localparam int EV_HALT        = 1;
    localparam int EV_PC_JUMP     = 2;
    localparam int EV_TABLE_DONE  = 3;
    localparam int NUM_EVENTS     = 4;
    // Dummy cycles after a program counter low write
    localparam int PCL_DUMMY_CYCLES = 1;

    typedef enum logic [3:0] {
        CSP_OP_NONE,
        CSP_OP_ADD,
        CSP_OP_ADC,
        CSP_OP_SUB,
        CSP_OP_SBC,
        CSP_OP_AND,
        CSP_OP_OR,
        CSP_OP_XOR,
        CSP_OP_RLC,
        CSP_OP_RRC,
        CSP_OP_MOV_TO_ACC,
        CSP_OP_MOV_FROM_ACC
    } csp_op_e;

    typedef enum logic [2:0] {
        CSP_CTL_NONE,
        CSP_CTL_JUMP,
        CSP_CTL_CALL,
        CSP_CTL_TABLE_READ,
        CSP_CTL_WDT_CLEAR,
        CSP_CTL_HALT
    } csp_ctl_e;

    // One issued instruction from the core sequencer
    typedef struct packed {
        logic       valid;
        csp_op_e    op;
        csp_ctl_e   ctl;
        logic [7:0] operand;
        logic       to_mem;
        logic [11:0] target;
    } csp_instr_s;

    // Write-back towards data memory
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } csp_wb_s;

    // Program memory fetch request
    typedef struct packed {
        logic        valid;
        logic [12:0] addr;
    } csp_pfetch_s;
endpackage : csp_pkg
`default_nettype wire

// File: hdl/csp_core_regs.sv
// The implementer's own choices: the address-and-strobe port and the register addresses.
`default_nettype none
module csp_core_regs #(
    parameter int PC_LOW_W = 8
) (
    input  wire logic                clk,
    input  wire logic                resetn,
    input  wire logic [3:0]          reg_addr,
    input  wire logic [7:0]          reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    output logic [7:0]               reg_rdata,
    input  wire csp_pkg::csp_instr_s instr,
    input  wire logic                wdt_timeout,
    input  wire logic [7:0]          mem_rdata,
    input  wire logic [15:0]         prog_rdata,
    input  wire logic                prog_rvalid,
    output csp_pkg::csp_pfetch_s     prog_fetch,
    output csp_pkg::csp_wb_s         mem_wb,
    output logic [12:0]              pc,
    output logic                     dummy_cycle,
    output logic                     irq
);
    import csp_pkg::*;

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic        bank_select_bit_q;
    logic [7:0]  status_q;
    logic [7:0]  acc_q;
    logic [7:0]  table_ptr_low_q;
    logic [7:0]  table_ptr_high_q;
    logic [7:0]  table_high_latch_q;
    logic [12:0] pc_q;
    logic        dummy_q;
    logic        tbl_busy_q;
    logic        tbl_to_mem_q;
    logic [NUM_EVENTS-1:0] ev_stat_q;
    logic [NUM_EVENTS-1:0] ev_mask_q;
    logic [7:0]  rdata_q;
    logic        irq_q;
    csp_pfetch_s fetch_q;
    csp_wb_s     wb_q;

    // ------------------------------------------------------------
    // Flag arithmetic
    // ------------------------------------------------------------
    function automatic logic [9:0] add8(input logic [7:0] a,
                                        input logic [7:0] b,
                                        input logic       cin);
        logic [7:0] s7;
        logic [8:0] s8;
        s7 = {1'b0, a[6:0]} + {1'b0, b[6:0]} + {7'h00, cin};
        s8 = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        // Carry out, overflow, result
        add8 = {s8[8], s7[7] ^ s8[8], s8[7:0]};
    endfunction : add8

    function automatic logic nib_carry(input logic [7:0] a,
                                       input logic [7:0] b,
                                       input logic       cin);
        logic [4:0] lo;
        lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        nib_carry = lo[4];
    endfunction : nib_carry

    logic [7:0] alu_res;
    logic [7:0] flags_d;
    logic       alu_writes;
    logic [9:0] sum;
    logic [7:0] rhs;
    logic       cin;

    always_comb
    begin
        rhs        = instr.operand;
        cin        = 1'b0;
        sum        = 10'h000;
        alu_res    = acc_q;
        flags_d    = status_q;
        alu_writes = 1'b0;
        unique case (instr.op)
            CSP_OP_ADD, CSP_OP_ADC, CSP_OP_SUB, CSP_OP_SBC:
            begin
                rhs = (instr.op inside {CSP_OP_SUB, CSP_OP_SBC}) ?
                      ~instr.operand : instr.operand;
                cin = (instr.op == CSP_OP_SUB) ||
                      (instr.op != CSP_OP_ADD && status_q[BIT_C]);
                sum     = add8(acc_q, rhs, cin);
                alu_res = sum[7:0];
                alu_writes = 1'b1;
                flags_d[BIT_C]  = sum[9];
                flags_d[BIT_AC] = nib_carry(acc_q, rhs, cin);
                flags_d[BIT_OV] = sum[8];
                flags_d[BIT_SC] = sum[8] ^ sum[7];
            end
            CSP_OP_AND, CSP_OP_OR, CSP_OP_XOR:
            begin
                alu_writes = 1'b1;
                alu_res = (instr.op == CSP_OP_AND) ? acc_q & instr.operand :
                          (instr.op == CSP_OP_OR)  ? acc_q | instr.operand :
                                                     acc_q ^ instr.operand;
            end
            CSP_OP_RLC:
            begin
                alu_writes = 1'b1;
                alu_res = {instr.operand[6:0], status_q[BIT_C]};
                flags_d[BIT_C] = instr.operand[7];
            end
            CSP_OP_RRC:
            begin
                alu_writes = 1'b1;
                alu_res = {status_q[BIT_C], instr.operand[7:1]};
                flags_d[BIT_C] = instr.operand[0];
            end
            CSP_OP_MOV_TO_ACC: alu_res = mem_rdata;
            default: alu_res = acc_q;
        endcase
        if (alu_writes)
        begin
            flags_d[BIT_Z] = (alu_res == 8'h00);
            if (instr.op == CSP_OP_SUB)
                flags_d[BIT_CZ] = flags_d[BIT_Z];
            else if (instr.op == CSP_OP_SBC)
                flags_d[BIT_CZ] = status_q[BIT_CZ]
                                & flags_d[BIT_Z];
        end
    end

    logic op_live;
    logic sw_wr;
    logic ctl_live;
    assign op_live  = instr.valid && !dummy_q && !tbl_busy_q;
    assign ctl_live = op_live;
    assign sw_wr    = reg_wr;

    // ------------------------------------------------------------
    // Accumulator and write-back
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            acc_q <= RST_BYTE;
            wb_q  <= '0;
        end
        else
        begin
            wb_q.valid <= 1'b0;
            if (sw_wr && reg_addr == OFS_ACC)
            begin
                acc_q <= reg_wdata;
            end
            else if (op_live && instr.op == CSP_OP_MOV_FROM_ACC)
            begin
                wb_q.valid <= 1'b1;
                wb_q.data  <= acc_q;
            end
            else if (op_live && (alu_writes ||
                     instr.op == CSP_OP_MOV_TO_ACC))
            begin
                if (instr.to_mem && alu_writes)
                begin
                    wb_q.valid <= 1'b1;
                    wb_q.data  <= alu_res;
                end
                else
                begin
                    acc_q <= alu_res;
                end
            end
            else if (tbl_busy_q && prog_rvalid && !tbl_to_mem_q)
            begin
                acc_q <= prog_rdata[7:0];
            end
            if (tbl_busy_q && prog_rvalid && tbl_to_mem_q)
            begin
                wb_q.valid <= 1'b1;
                wb_q.data  <= prog_rdata[7:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Status register
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            status_q <= RST_STATUS;
        end
        else
        begin
            // Flags land with the result, no save on call
            if (op_live)
            begin
                status_q[7:6] <= flags_d[7:6];
                status_q[3:0] <= flags_d[3:0];
            end
            if (sw_wr && reg_addr == OFS_STATUS)
            begin
                status_q <= (reg_wdata & SW_STATUS_MASK)
                          | (status_q & ~SW_STATUS_MASK);
            end
            if (ctl_live && instr.ctl == CSP_CTL_WDT_CLEAR)
            begin
                status_q[BIT_TO]  <= 1'b0;
                status_q[BIT_PDF] <= 1'b0;
            end
            else if (ctl_live && instr.ctl == CSP_CTL_HALT)
            begin
                status_q[BIT_TO]  <= 1'b0;
                status_q[BIT_PDF] <= 1'b1;
            end
            if (wdt_timeout)
            begin
                status_q[BIT_TO] <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Bank pointer, program counter, table pointer
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            bank_select_bit_q <= 1'b0;
        end
        else if (sw_wr && reg_addr == OFS_BANK_PTR)
        begin
            bank_select_bit_q <= reg_wdata[0];
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pc_q    <= 13'h0000;
            dummy_q <= 1'b0;
        end
        else
        begin
            dummy_q <= 1'b0;
            if (sw_wr && reg_addr == OFS_PC_LOW)
            begin
                pc_q[PC_LOW_W-1:0] <= reg_wdata;
                dummy_q <= 1'b1;
            end
            else if (ctl_live && (instr.ctl == CSP_CTL_JUMP ||
                                  instr.ctl == CSP_CTL_CALL))
            begin
                pc_q <= {bank_select_bit_q, instr.target};
            end
            else if (op_live)
            begin
                pc_q <= pc_q + 13'h0001;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            table_ptr_low_q    <= RST_BYTE;
            table_ptr_high_q   <= RST_BYTE;
            table_high_latch_q <= RST_BYTE;
            tbl_busy_q         <= 1'b0;
            tbl_to_mem_q       <= 1'b0;
            fetch_q            <= '0;
        end
        else
        begin
            fetch_q.valid <= 1'b0;
            if (sw_wr && reg_addr == OFS_TBL_LOW)
            begin
                table_ptr_low_q <= reg_wdata;
            end
            if (sw_wr && reg_addr == OFS_TBL_HIGH)
            begin
                table_ptr_high_q <= reg_wdata;
            end
            if (ctl_live && instr.ctl == CSP_CTL_TABLE_READ)
            begin
                tbl_busy_q    <= 1'b1;
                tbl_to_mem_q  <= instr.to_mem;
                fetch_q.valid <= 1'b1;
                fetch_q.addr  <= {table_ptr_high_q[4:0], table_ptr_low_q};
            end
            else if (tbl_busy_q && prog_rvalid)
            begin
                tbl_busy_q         <= 1'b0;
                table_high_latch_q <= prog_rdata[15:8];
            end
        end
    end

    // ------------------------------------------------------------
    // Events and interrupt
    // ------------------------------------------------------------
    logic [NUM_EVENTS-1:0] ev_now;
    always_comb
    begin
        ev_now = '0;
        ev_now[EV_WDT_TIMEOUT] = wdt_timeout;
        ev_now[EV_HALT]       = ctl_live && instr.ctl == CSP_CTL_HALT;
        ev_now[EV_PC_JUMP]    = sw_wr && reg_addr == OFS_PC_LOW;
        ev_now[EV_TABLE_DONE] = tbl_busy_q && prog_rvalid;
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ev_stat_q <= '0;
            ev_mask_q <= '0;
            irq_q     <= 1'b0;
        end
        else
        begin
            // Set beats the read-clear
            if (reg_rd && reg_addr == OFS_IRQ_STAT)
            begin
                ev_stat_q <= ev_now;
            end
            else
            begin
                ev_stat_q <= ev_stat_q | ev_now;
            end
            if (sw_wr && reg_addr == OFS_IRQ_MASK)
            begin
                ev_mask_q <= reg_wdata[NUM_EVENTS-1:0];
            end
            irq_q <= |(ev_stat_q & ev_mask_q);
        end
    end

    // ------------------------------------------------------------
    // Register read port
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rdata_q <= RST_BYTE;
        end
        else if (reg_rd)
        begin
            unique case (reg_addr)
                OFS_BANK_PTR:  rdata_q <= {7'h00, bank_select_bit_q};
                OFS_STATUS:    rdata_q <= status_q;
                OFS_PC_LOW:    rdata_q <= pc_q[7:0];
                OFS_PC_HIGH:   rdata_q <= {3'h0, pc_q[12:8]};
                OFS_TBL_LOW:   rdata_q <= table_ptr_low_q;
                OFS_TBL_HIGH:  rdata_q <= table_ptr_high_q;
                OFS_TBL_LATCH: rdata_q <= table_high_latch_q;
                OFS_ACC:       rdata_q <= acc_q;
                OFS_IRQ_STAT:  rdata_q <= {4'h0, ev_stat_q};
                OFS_IRQ_MASK:  rdata_q <= {4'h0, ev_mask_q};
                default:       rdata_q <= 8'h00;
            endcase
        end
        else
            rdata_q <= 8'h00;
    end

    assign reg_rdata   = rdata_q;
    assign prog_fetch  = fetch_q;
    assign mem_wb      = wb_q;
    assign pc          = pc_q;
    assign dummy_cycle = dummy_q;
    assign irq         = irq_q;
endmodule : csp_core_regs
`default_nettype wire

// File: tb/csp_core_regs_assertions.sv
`default_nettype none
module csp_core_regs_chk (
    input wire logic                 clk,
    input wire logic                 resetn,
    input wire logic [3:0]           reg_addr,
    input wire logic [7:0]           reg_wdata,
    input wire logic                 reg_wr,
    input wire logic                 reg_rd,
    input wire logic [7:0]           reg_rdata,
    input wire csp_pkg::csp_instr_s  instr,
    input wire logic                 wdt_timeout,
    input wire logic [7:0]           mem_rdata,
    input wire csp_pkg::csp_pfetch_s prog_fetch,
    input wire csp_pkg::csp_wb_s     mem_wb,
    input wire logic [12:0]          pc,
    input wire logic                 dummy_cycle
);
    timeunit 1ns;
    timeprecision 1ps;
    import csp_pkg::*;

    logic       bank_h;
    logic [7:0] tlo_h;
    logic [7:0] thi_h;
    logic [1:0] sys_h;
    logic       tk;

    assign tk = instr.valid && !dummy_cycle;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    // -------------------------------
    // Shadows of pointers and flags
    // -------------------------------
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            bank_h <= 1'b0;
            tlo_h  <= 8'h00;
            thi_h  <= 8'h00;
        end
        else if (reg_wr)
        begin
            if (reg_addr == OFS_BANK_PTR) bank_h <= reg_wdata[0];
            if (reg_addr == OFS_TBL_LOW) tlo_h <= reg_wdata;
            if (reg_addr == OFS_TBL_HIGH) thi_h <= reg_wdata;
        end
    end

    // Timeout wins over a clear in the same cycle
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            sys_h <= 2'b00;
        else
        begin
            if (wdt_timeout)
                sys_h[1] <= 1'b1;
            else if (tk && instr.ctl inside {CSP_CTL_WDT_CLEAR, CSP_CTL_HALT})
                sys_h[1] <= 1'b0;
            if (tk && instr.ctl == CSP_CTL_HALT)
                sys_h[0] <= 1'b1;
            else if (tk && instr.ctl == CSP_CTL_WDT_CLEAR)
                sys_h[0] <= 1'b0;
        end
    end

    // -------------------------------
    // Assertions
    // -------------------------------
    a_bank_hi_zero: assert property (
        reg_rd && reg_addr == OFS_BANK_PTR |=> reg_rdata[7:1] == 7'h00)
        else $error("bank upper bits not zero");
    a_sys_flags: assert property (
        reg_rd && reg_addr == OFS_STATUS |=> reg_rdata[5:4] == $past(sys_h))
        else $error("timeout or powerdown flag wrong");
    a_pcl_jump: assert property (
        reg_wr && reg_addr == OFS_PC_LOW |=> dummy_cycle
        && pc[7:0] == $past(reg_wdata) && pc[12:8] == $past(pc[12:8]))
        else $error("pc low write wrong");
    a_dummy_once: assert property (
        $rose(dummy_cycle) |=> !dummy_cycle)
        else $error("dummy cycle too long");
    a_branch_bank: assert property (
        tk && instr.ctl inside {CSP_CTL_JUMP, CSP_CTL_CALL}
        |=> pc == {$past(bank_h), $past(instr.target)})
        else $error("branch target wrong");
    a_fetch_addr: assert property (
        prog_fetch.valid |-> prog_fetch.addr == $past({thi_h[4:0], tlo_h}))
        else $error("table fetch address wrong");
    a_fetch_pulse: assert property (
        tk && instr.ctl == CSP_CTL_TABLE_READ
        |=> prog_fetch.valid ##1 !prog_fetch.valid)
        else $error("table fetch pulse wrong");
    a_acc_bypass: assert property (
        tk && instr.op == CSP_OP_MOV_TO_ACC
        ##1 tk && instr.op == CSP_OP_MOV_FROM_ACC
        |=> mem_wb.valid && mem_wb.data == $past(mem_rdata, 2))
        else $error("accumulator transfer wrong");
endmodule : csp_core_regs_chk
`default_nettype wire

// File: tb/csp_core_regs_tb_top.sv
`default_nettype none
module csp_core_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import csp_pkg::*;

    logic        clk;
    logic        resetn;
    logic [3:0]  reg_addr;
    logic [7:0]  reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_rdata;
    csp_instr_s  instr;
    logic        wdt_timeout;
    logic [7:0]  mem_rdata;
    logic [15:0] prog_rdata;
    logic        prog_rvalid;
    csp_pfetch_s prog_fetch;
    csp_wb_s     mem_wb;
    logic [12:0] pc;
    logic        dummy_cycle;
    logic        irq;
    int          mismatches;
    int          checks;
    int          cycles;
    logic [7:0]  d, a, b, c, s0;
    logic [15:0] w, e1, e2;
    logic [11:0] t;
    logic [12:0] p;
    logic [3:0]  o1, o2;

    csp_core_regs dut_u (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .instr(instr), .wdt_timeout(wdt_timeout),
        .mem_rdata(mem_rdata), .prog_rdata(prog_rdata),
        .prog_rvalid(prog_rvalid), .prog_fetch(prog_fetch),
        .mem_wb(mem_wb), .pc(pc), .dummy_cycle(dummy_cycle), .irq(irq));

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // -------------------------------
    // Bench tasks
    // -------------------------------
    task automatic close_out();
        if (mismatches == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : close_out

    task automatic check(input string n, input logic [15:0] s, e);
        checks++;
        if (s !== e)
        begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask : check

    task automatic wr(input logic [3:0] ad, input logic [7:0] v);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= ad;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] ad, output logic [7:0] v);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= ad;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        v = reg_rdata;
    endtask : rd

    task automatic exec(input csp_instr_s i1, input csp_instr_s i2);
        @(posedge clk);
        instr <= i1;
        @(posedge clk);
        instr <= i2;
        @(posedge clk);
        instr <= '0;
    endtask : exec

    task automatic pulse_wdt();
        @(posedge clk);
        wdt_timeout <= 1'b1;
        @(posedge clk);
        wdt_timeout <= 1'b0;
        repeat (2) @(negedge clk);
    endtask : pulse_wdt

    function automatic csp_instr_s mk(input logic [3:0] op,
        input csp_ctl_e ct, input logic [7:0] v, input logic m,
        input logic [11:0] tg);
        return '{1'b1, csp_op_e'(op), ct, v, m, tg};
    endfunction : mk

    function automatic logic [15:0] alu(input logic [3:0] op,
        input logic [7:0] x, v, st);
        logic [8:0] s;
        logic [7:0] u, y, r, f;
        logic [4:0] h;
        logic       ci;
        y = (op == CSP_OP_SUB || op == CSP_OP_SBC) ? ~v : v;
        ci = op == CSP_OP_SUB
            || ((op == CSP_OP_ADC || op == CSP_OP_SBC) && st[BIT_C]);
        s = {1'b0, x} + {1'b0, y} + 9'(ci);
        u = {1'b0, x[6:0]} + {1'b0, y[6:0]} + 8'(ci);
        h = {1'b0, x[3:0]} + {1'b0, y[3:0]} + 5'(ci);
        f = st;
        r = s[7:0];
        case (op)
            CSP_OP_NONE: return {st, x};
            CSP_OP_AND: r = x & v;
            CSP_OP_OR: r = x | v;
            CSP_OP_XOR: r = x ^ v;
            CSP_OP_RLC: {f[BIT_C], r} = {v, st[BIT_C]};
            CSP_OP_RRC: {r, f[BIT_C]} = {st[BIT_C], v};
            default:
            begin
                f[BIT_C] = s[8];
                f[BIT_AC] = h[4];
                f[BIT_OV] = u[7] ^ s[8];
                f[BIT_SC] = u[7] ^ s[8] ^ s[7];
            end
        endcase
        f[BIT_Z] = r == 8'h00;
        if (op == CSP_OP_SUB) f[BIT_CZ] = f[BIT_Z];
        if (op == CSP_OP_SBC) f[BIT_CZ] = st[BIT_CZ] & f[BIT_Z];
        return {f, r};
    endfunction : alu

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 8000)
        begin
            mismatches++;
            close_out();
        end
    end

    // -------------------------------
    // Scenarios
    // -------------------------------
    initial
    begin
        {resetn, reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
        {instr, wdt_timeout, mem_rdata, prog_rdata, prog_rvalid} = '0;
        {mismatches, checks, cycles} = '0;
        void'($urandom(50));
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        rd(OFS_BANK_PTR, d);
        check("bank", d, 8'h00);
        rd(OFS_STATUS, d);
        check("status", d, 8'h00);
        wr(OFS_BANK_PTR, 8'hFF);
        rd(OFS_BANK_PTR, d);
        check("bank", d, 8'h01);
        wr(4'hB, 8'hFF);
        rd(4'hB, d);
        check("unmapped", d, 8'h00);
        t = 12'($urandom);
        exec(mk(0, CSP_CTL_JUMP, 0, 0, t), '0);
        check("jump", pc, {1'b1, t});
        wr(OFS_BANK_PTR, 8'h00);
        rd(OFS_STATUS, s0);
        t = 12'($urandom);
        exec(mk(0, CSP_CTL_CALL, 0, 0, t), '0);
        check("call", pc, {1'b0, t});
        rd(OFS_STATUS, d);
        check("status", d, s0);
        p = pc;
        d = 8'($urandom);
        wr(OFS_PC_LOW, d);
        @(negedge clk);
        check("pcl", {dummy_cycle, pc}, {1'b1, p[12:8], d});
        @(negedge clk);
        check("dummy", dummy_cycle, 1'b0);
        wr(OFS_IRQ_MASK, 8'h00);
        rd(OFS_IRQ_STAT, d);
        pulse_wdt();
        check("irq", irq, 1'b0);
        rd(OFS_IRQ_STAT, d);
        check("event", d[0], 1'b1);
        rd(OFS_STATUS, d);
        check("status", d, 8'h20);
        wr(OFS_STATUS, 8'hFF);
        rd(OFS_STATUS, d);
        check("status", d, 8'hEF);
        wr(OFS_IRQ_MASK, 8'h01);
        pulse_wdt();
        check("irq", irq, 1'b1);
        rd(OFS_IRQ_STAT, d);
        repeat (2) @(negedge clk);
        check("irq", irq, 1'b0);
        exec(mk(0, CSP_CTL_HALT, 0, 0, 0), '0);
        rd(OFS_STATUS, d);
        check("halt", d[5:4], 2'b01);
        pulse_wdt();
        exec(mk(0, CSP_CTL_WDT_CLEAR, 0, 0, 0), '0);
        rd(OFS_STATUS, d);
        check("clear", d[5:4], 2'b00);
        rd(OFS_IRQ_STAT, d);
        check("event", d, 8'h03);
        c = 8'($urandom);
        mem_rdata <= c;
        exec(mk(CSP_OP_MOV_TO_ACC, CSP_CTL_NONE, 0, 0, 0),
             mk(CSP_OP_MOV_FROM_ACC, CSP_CTL_NONE, 0, 0, 0));
        @(negedge clk);
        check("wb", {mem_wb.valid, mem_wb.data}, {1'b1, c});
        for (int k = 0; k < 2; k++)
        begin
            w = 16'($urandom);
            prog_rdata <= ~w;
            wr(OFS_TBL_LOW, 8'($urandom));
            wr(OFS_TBL_HIGH, 8'($urandom));
            exec(mk(0, CSP_CTL_TABLE_READ, 0, k[0], 0), '0);
            repeat (2) @(posedge clk);
            {prog_rvalid, prog_rdata} <= {1'b1, w};
            @(posedge clk);
            {prog_rvalid, prog_rdata} <= {1'b0, ~w};
            @(negedge clk);
            check("tbl_wb", mem_wb.valid, k[0]);
            if (k == 1) check("tbl_wb", mem_wb.data, w[7:0]);
            rd(OFS_TBL_LATCH, d);
            check("latch", d, w[15:8]);
            rd(OFS_ACC, d);
            if (k == 0) check("tbl_lo", d, w[7:0]);
        end
        for (int i = 0; i < 48; i++)
        begin
            {a, b, c} = 24'($urandom);
            o1 = 4'($urandom_range(9, 1));
            o2 = i < 4 ? 4'h0 : 4'($urandom_range(9, 1));
            if (i < 4) {o1, a, b} = i == 0 ? 20'h18080 : i == 1 ? 20'h10F01
                : i == 2 ? 20'h30505 : 20'h47F80;
            c = c & SW_STATUS_MASK;
            wr(OFS_ACC, a);
            wr(OFS_STATUS, c);
            e1 = alu(o1, a, b, c);
            e2 = alu(o2, e1[7:0], ~b, e1[15:8]);
            exec(mk(o1, CSP_CTL_NONE, b, 0, 0), mk(o2, CSP_CTL_NONE, ~b, 0, 0));
            rd(OFS_ACC, d);
            check("acc", d, e2[7:0]);
            rd(OFS_STATUS, d);
            check("flags", d, e2[15:8]);
            check("chain", d[7:6], e2[15:14]);
        end
        close_out();
    end
endmodule : csp_core_regs_tb_top

bind csp_core_regs csp_core_regs_chk chk_u (.clk(clk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .instr(instr),
    .wdt_timeout(wdt_timeout), .mem_rdata(mem_rdata),
    .prog_fetch(prog_fetch), .mem_wb(mem_wb), .pc(pc),
    .dummy_cycle(dummy_cycle));
`default_nettype wire
